// [rtl/sica_crc_audio_regs.vh]
// register map, field positions and reset values of the crc and audio configuration block
// Summary of operation
// - received frames feed an 8/16-bit read-only CRC
// - sent frames feed an 8/16-bit read-only CRC
// - setting crc_enable zeroes both CRC values
// - channel_width_sel picks 16 or 32-bit channels
// - channel width auto-widened if below sample width
// - sample_width_sel: 16, 24, 32 bits; 11 forbidden
// - idle_clock_level sets idle serial clock level
// - audio_standard_sel picks I2S, left, right, PCM
// - pcm_sync_length_sel short/long sync, PCM only
// - audio_role_dir_sel picks master/slave and direction
// - audio_enable switches audio, ignored in SPI mode
// - serial_protocol_sel: 0 SPI, 1 I2S
// - audio fields ignored in SPI mode
// - CRC mismatch sets flag, cleared by writing zero
// - both CRCs use programmable polynomial, reset 0x0007
`ifndef SICA_CRC_AUDIO_REGS_VH
`define SICA_CRC_AUDIO_REGS_VH
// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define SICA_OFS_CTRL 6'h00
`define SICA_OFS_STATUS 6'h08
`define SICA_OFS_DATA 6'h0C
`define SICA_OFS_POLY 6'h10
`define SICA_OFS_RECEIVED_CRC_VALUE 6'h14
`define SICA_OFS_SENT_CRC_VALUE 6'h18
`define SICA_OFS_ACFG 6'h1C
`define SICA_OFS_IRQST 6'h24
`define SICA_OFS_IRQMSK 6'h28
// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define SICA_CTRL_SPIEN 0
`define SICA_CTRL_CRC_ENABLE 1
`define SICA_CTRL_FRM16 2
`define SICA_CTRL_CRCCHK 3
`define SICA_CTRL_MASK 16'h000F
`define SICA_STS_BUSY 0
`define SICA_STS_CRCERR 4
`define SICA_ACFG_CHAN 0
`define SICA_ACFG_SAMP 2:1
`define SICA_ACFG_IDLE 3
`define SICA_ACFG_STD 5:4
`define SICA_ACFG_SYNC 7
`define SICA_ACFG_ROLE 9:8
`define SICA_ACFG_AEN 10
`define SICA_ACFG_PROT 11
`define SICA_ACFG_CFGMASK 16'h03BF
`define SICA_ACFG_MASK 16'h0FBF
`define SICA_SAMP_BAD 2'h3
`define SICA_SAMP_16 2'h0
`define SICA_STD_PCM 2'h3
`define SICA_IRQ_RX 0
`define SICA_IRQ_TX 1
`define SICA_IRQ_CRC 2
`define SICA_IRQ_MASK 16'h0007
// ----------------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------------
`define SICA_POLY_RST 16'h0007
`define SICA_RESP_OKAY 2'h0
`define SICA_RESP_SLVERR 2'h2
`endif

// [rtl/sica_crc_audio.v]
// crc unit and audio configuration of the shared spi/i2s serial port, axi4-lite slave
`timescale 1ns/1ps
`include "sica_crc_audio_regs.vh"
module sica_crc_audio #(
  parameter ADDR_W = 6
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire linkSclk,
  input wire linkSel_b,
  input wire linkDataIn,
  output reg linkDataOut_q,
  output reg irq_q,
  output reg audioActive_q,
  output reg audioChan32_q,
  output reg [1:0] audioSampleWidth_q,
  output reg audioIdleHigh_q,
  output reg [1:0] audioStandard_q,
  output reg audioLongSync_q,
  output reg [1:0] audioRoleDir_q,
  output reg protocolI2s_q
);
  // --------------------------------------------------------------------------
  // reset release and link synchronisers
  // --------------------------------------------------------------------------
  reg rstS1_q, rstN_q;
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstS1_q <= 1'b0;
      rstN_q <= 1'b0;
    end
    else
    begin
      rstS1_q <= 1'b1;
      rstN_q <= rstS1_q;
    end
  end

  reg [2:0] linkS1_q, linkS2_q;
  reg sclkPrev_q;
  always @(posedge clk_sys or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      // idle levels: select high, clock low, data low, so no false edge after reset
      linkS1_q <= 3'h4;
      linkS2_q <= 3'h4;
      sclkPrev_q <= 1'b0;
    end
    else
    begin
      linkS1_q <= {linkSel_b, linkSclk, linkDataIn};
      linkS2_q <= linkS1_q;
      sclkPrev_q <= linkS2_q[1];
    end
  end
  wire selB = linkS2_q[2];
  wire sclkRise = linkS2_q[1] & ~sclkPrev_q;
  wire sclkFall = ~linkS2_q[1] & sclkPrev_q;
  wire dIn = linkS2_q[0];

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [15:0] ctrl_q, poly_q, received_crc_value_q, sent_crc_value_q, acfg_q, txData_q, rxData_q;
  reg [15:0] irqSt_q, irqMsk_q;
  reg crcErr_q, busy_q;
  wire frm16 = ctrl_q[`SICA_CTRL_FRM16];
  wire protI2s = acfg_q[`SICA_ACFG_PROT];
  wire spiActive = ctrl_q[`SICA_CTRL_SPIEN] & ~protI2s;
  wire crcOn = ctrl_q[`SICA_CTRL_CRC_ENABLE];

  // one frame folded msb first; the 8-bit form uses only the low polynomial bits
  function [15:0] crcFold;
    input [15:0] crc;
    input [15:0] word;
    input [15:0] poly;
    input wide;
    integer i;
    reg [15:0] c;
    reg fb;
    begin
      c = crc;
      for (i = 15; i >= 0; i = i - 1)
      begin
        if (wide || i < 8)
        begin
          fb = (wide ? c[15] : c[7]) ^ word[i];
          c = {c[14:0], 1'b0};
          if (fb)
            c = c ^ poly;
          if (!wide)
            c = {8'h00, c[7:0]};
        end
      end
      crcFold = c;
    end
  endfunction

  // --------------------------------------------------------------------------
  // serial frame engine
  // --------------------------------------------------------------------------
  reg [15:0] rxShift_q, txShift_q;
  reg [3:0] bitCnt_q;
  reg selPrev_q;
  wire [3:0] lastBit = frm16 ? 4'hF : 4'h7;
  wire [15:0] rxWord = frm16 ? {rxShift_q[14:0], dIn} : {8'h00, rxShift_q[6:0], dIn};
  wire frameDone = spiActive & ~selB & sclkRise & (bitCnt_q == lastBit);
  wire frameStart = spiActive & ~selB & selPrev_q;
  wire crcCheck = ctrl_q[`SICA_CTRL_CRCCHK];
  wire crcBad = frameDone & crcCheck & (rxWord != received_crc_value_q);

  always @(posedge clk_sys or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      rxShift_q <= 16'h0000;
      txShift_q <= 16'h0000;
      bitCnt_q <= 4'h0;
      selPrev_q <= 1'b1;
      linkDataOut_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      selPrev_q <= selB;
      busy_q <= spiActive & ~selB;
      linkDataOut_q <= txShift_q[15];
      if (frameStart)
      begin
        txShift_q <= frm16 ? txData_q : {txData_q[7:0], 8'h00};
        bitCnt_q <= 4'h0;
      end
      else if (spiActive && !selB)
      begin
        if (sclkRise)
        begin
          rxShift_q <= {rxShift_q[14:0], dIn};
          bitCnt_q <= frameDone ? 4'h0 : bitCnt_q + 4'h1;
        end
        if (sclkFall)
          txShift_q <= {txShift_q[14:0], 1'b0};
      end
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite write path
  // --------------------------------------------------------------------------
  reg [ADDR_W-1:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg awHave_q, wHave_q;
  wire doWrite = awHave_q & wHave_q & ~s_axi_bvalid;
  wire [15:0] laneMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire [5:0] wOfs = {awAddr_q[5:2], 2'b00};
  wire wrCtrl = doWrite && (wOfs == `SICA_OFS_CTRL);
  wire wrStatus = doWrite && (wOfs == `SICA_OFS_STATUS);
  wire wrData = doWrite && (wOfs == `SICA_OFS_DATA);
  wire wrPoly = doWrite && (wOfs == `SICA_OFS_POLY);
  wire wrAcfg = doWrite && (wOfs == `SICA_OFS_ACFG);
  wire wrMsk = doWrite && (wOfs == `SICA_OFS_IRQMSK);
  wire wrKnown = wrCtrl | wrStatus | wrData | wrPoly | wrAcfg | wrMsk
    | (doWrite && (wOfs == `SICA_OFS_RECEIVED_CRC_VALUE || wOfs == `SICA_OFS_SENT_CRC_VALUE
    || wOfs == `SICA_OFS_IRQST));
  wire [15:0] ctrlNew = ((ctrl_q & ~laneMask) | (wData_q[15:0] & laneMask)) & `SICA_CTRL_MASK;
  wire crcEnRise = wrCtrl & ctrlNew[`SICA_CTRL_CRC_ENABLE] & ~crcOn;
  wire [15:0] acfgMerge = (acfg_q & ~laneMask) | (wData_q[15:0] & laneMask);
  wire audioOn = acfg_q[`SICA_ACFG_AEN];

  always @(posedge clk_sys or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= {ADDR_W{1'b0}};
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SICA_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~awHave_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~wHave_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? `SICA_RESP_OKAY : `SICA_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  wire rdIrq;
  always @(posedge clk_sys or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      ctrl_q <= 16'h0000;
      poly_q <= `SICA_POLY_RST;
      received_crc_value_q <= 16'h0000;
      sent_crc_value_q <= 16'h0000;
      acfg_q <= 16'h0000;
      txData_q <= 16'h0000;
      rxData_q <= 16'h0000;
      crcErr_q <= 1'b0;
      irqSt_q <= 16'h0000;
      irqMsk_q <= 16'h0000;
    end
    else
    begin
      if (wrCtrl)
        ctrl_q <= ctrlNew;
      if (frameDone && crcCheck)
        ctrl_q[`SICA_CTRL_CRCCHK] <= 1'b0;
      if (wrPoly)
        poly_q <= (poly_q & ~laneMask) | (wData_q[15:0] & laneMask);
      if (wrData)
        txData_q <= (txData_q & ~laneMask) | (wData_q[15:0] & laneMask);
      if (wrMsk)
        irqMsk_q <= ((irqMsk_q & ~laneMask) | (wData_q[15:0] & laneMask)) & `SICA_IRQ_MASK;
      if (frameDone)
        rxData_q <= rxWord;
      if (crcEnRise)
      begin
        received_crc_value_q <= 16'h0000;
        sent_crc_value_q <= 16'h0000;
      end
      else if (frameDone && crcOn)
      begin
        if (!crcCheck)
          received_crc_value_q <= crcFold(received_crc_value_q, rxWord, poly_q, frm16);
        sent_crc_value_q <= crcFold(sent_crc_value_q, frm16 ? txData_q : {8'h00, txData_q[7:0]},
          poly_q, frm16);
      end
      // hardware set wins over a software write of zero
      if (crcBad)
        crcErr_q <= 1'b1;
      else if (wrStatus && wStrb_q[0] && !wData_q[`SICA_STS_CRCERR])
        crcErr_q <= 1'b0;
      if (wrAcfg)
      begin
        acfg_q[`SICA_ACFG_AEN] <= acfgMerge[`SICA_ACFG_AEN];
        // protocol is only switched with both engines off
        if (!audioOn && !ctrl_q[`SICA_CTRL_SPIEN])
          acfg_q[`SICA_ACFG_PROT] <= acfgMerge[`SICA_ACFG_PROT];
        // audio fields frozen while audio_enable is set, even in SPI mode; reserved bits never stored
        if (!audioOn)
        begin
          acfg_q[`SICA_ACFG_CHAN] <= acfgMerge[`SICA_ACFG_CHAN];
          acfg_q[`SICA_ACFG_IDLE] <= acfgMerge[`SICA_ACFG_IDLE];
          acfg_q[`SICA_ACFG_STD] <= acfgMerge[`SICA_ACFG_STD];
          acfg_q[`SICA_ACFG_SYNC] <= acfgMerge[`SICA_ACFG_SYNC];
          acfg_q[`SICA_ACFG_ROLE] <= acfgMerge[`SICA_ACFG_ROLE];
          if (acfgMerge[`SICA_ACFG_SAMP] != `SICA_SAMP_BAD)
            acfg_q[`SICA_ACFG_SAMP] <= acfgMerge[`SICA_ACFG_SAMP];
        end
      end
      // events set, read of the interrupt status register clears, set wins
      irqSt_q <= ((rdIrq ? 16'h0000 : irqSt_q)
        | {13'h0000, crcBad, frameDone, frameDone}) & `SICA_IRQ_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // audio configuration outputs and interrupt
  // --------------------------------------------------------------------------
  wire audioMode = protI2s;
  always @(posedge clk_sys or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      audioActive_q <= 1'b0;
      audioChan32_q <= 1'b0;
      audioSampleWidth_q <= `SICA_SAMP_16;
      audioIdleHigh_q <= 1'b0;
      audioStandard_q <= 2'h0;
      audioLongSync_q <= 1'b0;
      audioRoleDir_q <= 2'h0;
      protocolI2s_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      protocolI2s_q <= protI2s;
      audioActive_q <= audioMode & audioOn;
      // a 16-bit channel cannot hold a wider sample, so it is widened
      audioChan32_q <= audioMode & (acfg_q[`SICA_ACFG_CHAN]
        | (acfg_q[`SICA_ACFG_SAMP] != `SICA_SAMP_16));
      audioSampleWidth_q <= audioMode ? acfg_q[`SICA_ACFG_SAMP] : `SICA_SAMP_16;
      audioIdleHigh_q <= audioMode & acfg_q[`SICA_ACFG_IDLE];
      audioStandard_q <= audioMode ? acfg_q[`SICA_ACFG_STD] : 2'h0;
      audioLongSync_q <= audioMode & (acfg_q[`SICA_ACFG_STD] == `SICA_STD_PCM)
        & acfg_q[`SICA_ACFG_SYNC];
      audioRoleDir_q <= audioMode ? acfg_q[`SICA_ACFG_ROLE] : 2'h0;
      irq_q <= |(irqSt_q & irqMsk_q);
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite read path
  // --------------------------------------------------------------------------
  wire [5:0] rOfs = {s_axi_araddr[5:2], 2'b00};
  wire rdTake = s_axi_arvalid & s_axi_arready;
  assign rdIrq = rdTake && (rOfs == `SICA_OFS_IRQST);
  reg [15:0] rdVal;
  reg rdOk;
  always @*
  begin
    rdVal = 16'h0000;
    rdOk = 1'b1;
    if (rOfs == `SICA_OFS_CTRL)
      rdVal = ctrl_q;
    else if (rOfs == `SICA_OFS_STATUS)
      rdVal = {11'h000, crcErr_q, 3'h0, busy_q};
    else if (rOfs == `SICA_OFS_DATA)
      rdVal = rxData_q;
    else if (rOfs == `SICA_OFS_POLY)
      rdVal = poly_q;
    else if (rOfs == `SICA_OFS_RECEIVED_CRC_VALUE)
      rdVal = received_crc_value_q;
    else if (rOfs == `SICA_OFS_SENT_CRC_VALUE)
      rdVal = sent_crc_value_q;
    else if (rOfs == `SICA_OFS_ACFG)
      rdVal = acfg_q & `SICA_ACFG_MASK;
    else if (rOfs == `SICA_OFS_IRQST)
      rdVal = irqSt_q;
    else if (rOfs == `SICA_OFS_IRQMSK)
      rdVal = irqMsk_q;
    else
      rdOk = 1'b0;
  end

  always @(posedge clk_sys or negedge rstN_q)
  begin
    if (!rstN_q)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SICA_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rdTake)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rdVal};
        s_axi_rresp <= rdOk ? `SICA_RESP_OKAY : `SICA_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [bench/sica_crc_audio_props.sv]
// port checker of the crc and audio configuration block
`timescale 1ns/1ps
module sica_crc_audio_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic irq_q,
  input wire logic audioActive_q,
  input wire logic audioChan32_q,
  input wire logic [1:0] audioSampleWidth_q,
  input wire logic audioIdleHigh_q,
  input wire logic [1:0] audioStandard_q,
  input wire logic audioLongSync_q,
  input wire logic [1:0] audioRoleDir_q,
  input wire logic protocolI2s_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire [8:0] cfgOut = {audioChan32_q, audioSampleWidth_q, audioIdleHigh_q, audioStandard_q,
    audioLongSync_q, audioRoleDir_q};
  property p_sync_pcm;
    audioLongSync_q |-> audioStandard_q == 2'h3;
  endproperty
  a_sync_pcm: assert property (p_sync_pcm) else $error("long sync outside pcm");
  property p_samp_legal;
    audioSampleWidth_q != 2'h3;
  endproperty
  a_samp_legal: assert property (p_samp_legal) else $error("illegal sample width");
  property p_widen;
    protocolI2s_q && audioSampleWidth_q != 2'h0 |-> audioChan32_q;
  endproperty
  a_widen: assert property (p_widen) else $error("channel not widened");
  property p_spi_quiet;
    !protocolI2s_q |-> cfgOut == 9'h000 && !audioActive_q;
  endproperty
  a_spi_quiet: assert property (p_spi_quiet) else $error("audio fields seen in spi");
  property p_active;
    audioActive_q |-> protocolI2s_q;
  endproperty
  a_active: assert property (p_active) else $error("audio active in spi");
  property p_frozen;
    audioActive_q && $past(audioActive_q) |-> $stable(cfgOut);
  endproperty
  a_frozen: assert property (p_frozen) else $error("fields moved while active");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_active: cover property (audioActive_q);
  c_irq: cover property (irq_q);
endmodule
bind sica_crc_audio sica_crc_audio_props i_props (.*);

// [bench/sica_spi_master.sv]
// far-side spi master driving the serial link of the block
`timescale 1ns/1ps
module sica_spi_master (
  output logic linkSclk,
  output logic linkSel_b,
  output logic linkDataIn,
  input wire logic linkDataOut_q
);
  initial
  begin
    linkSclk = 1'b0;
    linkSel_b = 1'b1;
    linkDataIn = 1'b0;
  end
  // mode 0 frame, 400 ns link period, msb first; clock stands low outside frames
  task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
    rx = 16'h0000;
    #37 linkSel_b = 1'b0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      linkDataIn = tx[i];
      #200 linkSclk = 1'b1;
      rx = {rx[14:0], linkDataOut_q};
      #200 linkSclk = 1'b0;
    end
    #200 linkSel_b = 1'b1;
    // released line flips so a stale bit can never pass for data
    linkDataIn = ~linkDataIn;
  endtask
endmodule

// [bench/tb_top.sv]
// testbench of the crc and audio configuration block
`timescale 1ns/1ps
`include "sica_crc_audio_regs.vh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire linkSclk, linkSel_b, linkDataIn, linkDataOut_q, irq_q;
  wire audioActive_q, audioChan32_q, audioIdleHigh_q, audioLongSync_q, protocolI2s_q;
  wire [1:0] audioSampleWidth_q, audioStandard_q, audioRoleDir_q;
  wire [10:0] cfgOuts = {protocolI2s_q, audioActive_q, audioRoleDir_q, audioLongSync_q,
    audioStandard_q, audioIdleHigh_q, audioSampleWidth_q, audioChan32_q};
  int failCount = 0;
  int samplesChecked = 0;
  logic [15:0] received_crc_value, sent_crc_value, linkRx;
  always #25 clk_sys = ~clk_sys;
  sica_crc_audio i_dut (.*);
  sica_spi_master i_link (.*);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      failCount++;
    end
  endtask
  task automatic test_done;
    if (failCount == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 50)
    begin
      chk("bus answer", 32'h1, 32'h0);
      test_done;
    end
  endtask
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    logic ga, gw;
    n = 0;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      ga = ga | s_axi_awready;
      gw = gw | s_axi_wready;
      s_axi_awvalid <= !ga;
      s_axi_wvalid <= !gw;
    end
    while (!(ga && gw) && n < 50);
    @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    do
      @(posedge clk_sys);
    while (!s_axi_bvalid && ++n < 50);
    s_axi_bready <= 1'b0;
    guard(n);
    chk("write response", er, s_axi_bresp);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge clk_sys);
    while (!s_axi_arready && ++n < 50);
    s_axi_arvalid <= 1'b0;
    @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do
      @(posedge clk_sys);
    while (!s_axi_rvalid && ++n < 50);
    s_axi_rready <= 1'b0;
    guard(n);
    chk("read response", er, s_axi_rresp);
    chk("read data", e, s_axi_rdata);
  endtask
  function automatic logic [10:0] cfgExp(input logic [15:0] c);
    logic [10:0] e;
    e = {c[11:7], c[5:0]};
    e[9] = c[11] & c[10];
    e[6] = e[6] & (c[5:4] == 2'h3);
    e[0] = e[0] | (c[2:1] != 2'h0);
    return c[11] ? e : 11'h000;
  endfunction
  function automatic logic [15:0] crcf(input logic [15:0] c, input logic [15:0] d,
    input logic [15:0] p, input int nb);
    logic fb;
    for (int i = nb - 1; i >= 0; i--)
    begin
      fb = c[nb - 1] ^ d[i];
      c = c << 1;
      if (fb)
        c = c ^ p;
    end
    return nb == 8 ? {8'h00, c[7:0]} : c;
  endfunction
  task automatic cfg(input logic [15:0] c, input logic [15:0] rb);
    axw(`SICA_OFS_ACFG, {16'h0000, c});
    rdchk(`SICA_OFS_ACFG, {16'h0000, rb});
    chk("config outputs", cfgExp(rb), cfgOuts);
  endtask
  task automatic frame(input logic [15:0] txw, input logic [15:0] rxw, input int nb);
    axw(`SICA_OFS_DATA, {16'h0000, txw});
    i_link.xfer(rxw, nb, linkRx);
    repeat (4) @(posedge clk_sys);
    chk("link bits", txw, linkRx);
  endtask
  task automatic t_reset;
    rdchk(`SICA_OFS_RECEIVED_CRC_VALUE, 32'h0);
    rdchk(`SICA_OFS_SENT_CRC_VALUE, 32'h0);
    rdchk(`SICA_OFS_ACFG, 32'h0);
    rdchk(`SICA_OFS_POLY, `SICA_POLY_RST);
    rdchk(6'h04, 32'h0, `SICA_RESP_SLVERR);
    axw(6'h04, 32'hFFFF, `SICA_RESP_SLVERR);
    axw(`SICA_OFS_RECEIVED_CRC_VALUE, 32'h1234);
    rdchk(`SICA_OFS_RECEIVED_CRC_VALUE, 32'h0);
  endtask
  task automatic t_audio;
    logic [15:0] c;
    cfg(16'h0800, 16'h0800);
    for (int i = 0; i < 4; i++)
    begin
      c = 16'h0880 | (i << 4) | ((3 - i) << 8) | ((i % 3) << 1) | (i == 0) | ((i & 1) << 3);
      cfg(c, c);
    end
    cfg(16'h08BE, 16'h08B8);
    cfg(16'hF8C0, 16'h0880);
    cfg(16'h0C00, 16'h0C00);
    cfg(16'h0335, 16'h0800);
    cfg(16'h0000, 16'h0000);
    cfg(16'h07BB, 16'h07BB);
    cfg(16'h0000, 16'h03BB);
    cfg(16'h0000, 16'h0000);
  endtask
  task automatic t_crc8;
    axw(`SICA_OFS_CTRL, 32'h3);
    frame(16'h00A5, 16'h003C, 8);
    rdchk(`SICA_OFS_STATUS, 32'h0);
    rdchk(`SICA_OFS_DATA, 32'h3C);
    rdchk(`SICA_OFS_RECEIVED_CRC_VALUE, crcf(16'h0, 16'h3C, 16'h7, 8));
    rdchk(`SICA_OFS_SENT_CRC_VALUE, crcf(16'h0, 16'hA5, 16'h7, 8));
    chk("masked interrupt", 32'h0, irq_q);
  endtask
  task automatic t_crc16;
    axw(`SICA_OFS_POLY, 32'h8005);
    axw(`SICA_OFS_CTRL, 32'h1);
    axw(`SICA_OFS_CTRL, 32'h7);
    rdchk(`SICA_OFS_RECEIVED_CRC_VALUE, 32'h0);
    rdchk(`SICA_OFS_SENT_CRC_VALUE, 32'h0);
    received_crc_value = crcf(16'h0, 16'hBEEF, 16'h8005, 16);
    sent_crc_value = crcf(16'h0, 16'h1234, 16'h8005, 16);
    frame(16'h1234, 16'hBEEF, 16);
    rdchk(`SICA_OFS_RECEIVED_CRC_VALUE, received_crc_value);
    rdchk(`SICA_OFS_SENT_CRC_VALUE, sent_crc_value);
    axw(`SICA_OFS_CTRL, 32'hF);
    frame(16'h00FF, received_crc_value ^ 16'h0001, 16);
    rdchk(`SICA_OFS_STATUS, 32'h10);
    rdchk(`SICA_OFS_RECEIVED_CRC_VALUE, received_crc_value);
    rdchk(`SICA_OFS_SENT_CRC_VALUE, crcf(sent_crc_value, 16'h00FF, 16'h8005, 16));
    axw(`SICA_OFS_IRQMSK, 32'h4);
    repeat (3) @(posedge clk_sys);
    chk("interrupt", 32'h1, irq_q);
    rdchk(`SICA_OFS_IRQST, 32'h7);
    repeat (3) @(posedge clk_sys);
    chk("interrupt", 32'h0, irq_q);
    axw(`SICA_OFS_STATUS, 32'h0);
    rdchk(`SICA_OFS_STATUS, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset;
    t_audio;
    t_crc8;
    t_crc16;
    test_done;
  end
endmodule
